/* logic/gpio_port_bank.sv */
`include "gpio_bank_defines.svh"
`default_nettype none

module gpio_port_bank
  import gpio_bank_pkg::*;
#(
  parameter port_byte_t MASK_B = `GB_MASK_PORT_B,
  parameter port_byte_t MASK_F = `GB_MASK_PORT_F
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [`GB_ADDR_W-1:0] addr_i,
  input wire acc_op_t op_i,
  input wire port_byte_t wr_data_i,
  input wire logic [2:0] bit_idx_i,
  input wire logic rd_en_i,
  output port_byte_t rd_data_o,
  input wire logic [`GB_NUM_PORTS-1:0][7:0] pin_i,
  output logic [`GB_NUM_PORTS-1:0][7:0] pin_o,
  output logic [`GB_NUM_PORTS-1:0][7:0] pin_oe_n_o,
  output logic [`GB_NUM_PORTS-1:0][7:0] pullup_en_o,
  input wire logic lowpower_i,
  output logic wake_req_o
);

  // ----------------------------------------------------------------
  // implemented bits per port, a last
  // ----------------------------------------------------------------
  localparam logic [`GB_NUM_PORTS-1:0][7:0] IMPL_MASKS = {
    `GB_MASK_FULL, // g
    MASK_F,        // f
    `GB_MASK_FULL, // e
    `GB_MASK_FULL, // d
    `GB_MASK_FULL, // c
    MASK_B,        // b
    `GB_MASK_FULL  // a
  };

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  logic [2:0] port_sel;
  logic [1:0] kind_sel;
  logic port_hit;
  logic wake_hit;
  logic reg_hit;
  logic wr_any;
  logic bit_op;

  assign port_sel = addr_i[`GB_PORT_MSB:`GB_PORT_LSB];
  assign kind_sel = addr_i[`GB_KIND_MSB:`GB_KIND_LSB];
  assign port_hit = (port_sel <= `GB_PORT_LAST);
  // only port a has a wake enable register; other kind-3 slots are holes
  assign wake_hit = (port_sel == `GB_PORT_A) && (kind_sel == `GB_KIND_WAKE);
  assign reg_hit = port_hit && ((kind_sel != `GB_KIND_WAKE) || wake_hit);
  assign bit_op = (op_i == ACC_SET) || (op_i == ACC_CLR);
  assign wr_any = reg_hit && (op_i != ACC_IDLE);

  // ----------------------------------------------------------------
  // per-port cells
  // ----------------------------------------------------------------
  logic [`GB_NUM_PORTS-1:0][7:0] cell_data;
  logic [`GB_NUM_PORTS-1:0][7:0] cell_dir;
  logic [`GB_NUM_PORTS-1:0][7:0] cell_pullup;
  logic [`GB_NUM_PORTS-1:0][7:0] cell_read;
  logic [`GB_NUM_PORTS-1:0] data_we;
  logic [`GB_NUM_PORTS-1:0] dir_we;
  logic [`GB_NUM_PORTS-1:0] pullup_we;
  port_byte_t wr_val;

  genvar g;
  generate
    for (g = 0; g < `GB_NUM_PORTS; g = g + 1) begin : g_port
      logic this_port;
      assign this_port = wr_any && (port_sel == 3'(g));
      assign data_we[g] = this_port && (kind_sel == `GB_KIND_DATA);
      assign dir_we[g] = this_port && (kind_sel == `GB_KIND_DIR);
      assign pullup_we[g] = this_port && (kind_sel == `GB_KIND_PULLUP);

      // cell holds latch, direction and pull-high with their reset values
      port_cell #(
        .IMPL_MASK(IMPL_MASKS[g])
      ) u_cell (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .wr_val_i(wr_val),
        .data_we_i(data_we[g]),
        .dir_we_i(dir_we[g]),
        .pullup_we_i(pullup_we[g]),
        .pin_i(pin_i[g]),
        .data_o(cell_data[g]),
        .dir_o(cell_dir[g]),
        .pullup_o(cell_pullup[g]),
        .oe_n_o(pin_oe_n_o[g]),
        .pull_en_o(pullup_en_o[g]),
        .read_o(cell_read[g])
      );

      // pad data comes straight from the latch flops
      assign pin_o[g] = cell_data[g];
    end
  endgenerate

  // ----------------------------------------------------------------
  // port a wake enable register
  // ----------------------------------------------------------------
  port_byte_t wake_en_r, wake_en_nxt;
  logic wake_we;

  assign wake_we = wr_any && wake_hit;
  assign wake_en_nxt = wake_we ? wr_val : wake_en_r;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wake_en_r <= `GB_WAKE_RST;
    end else begin
      wake_en_r <= wake_en_nxt;
    end
  end

  // ----------------------------------------------------------------
  // read selection
  // ----------------------------------------------------------------
  port_byte_t sel_data;
  port_byte_t sel_dir;
  port_byte_t sel_pullup;
  port_byte_t kind_read;
  port_byte_t cur_read;

  assign sel_data = port_hit ? cell_read[port_sel] : `GB_BYTE_ZERO;
  assign sel_dir = port_hit ? cell_dir[port_sel] : `GB_BYTE_ZERO;
  assign sel_pullup = port_hit ? cell_pullup[port_sel] : `GB_BYTE_ZERO;
  assign kind_read = (kind_sel == `GB_KIND_DATA) ? sel_data :
                     (kind_sel == `GB_KIND_DIR) ? sel_dir :
                     (kind_sel == `GB_KIND_PULLUP) ? sel_pullup :
                     wake_en_r;
  // holes in the map read as zero
  assign cur_read = reg_hit ? kind_read : `GB_BYTE_ZERO;

  // ----------------------------------------------------------------
  // write value, including read-modify-write bit operations
  // ----------------------------------------------------------------
  // a bit op on a data register folds the live level of every input pin
  // into the latch; that is the documented behaviour, not a bug here
  port_byte_t bit_mask;
  port_byte_t rmw_val;

  assign bit_mask = `GB_BIT_ONE << bit_idx_i;
  assign rmw_val = (op_i == ACC_SET) ? (cur_read | bit_mask) :
                   (cur_read & ~bit_mask);
  assign wr_val = bit_op ? rmw_val : wr_data_i;

  // ----------------------------------------------------------------
  // read data register
  // ----------------------------------------------------------------
  // the pin is sampled on the read edge itself; the level must already be
  // settled then, nothing earlier is held
  port_byte_t rd_data_r, rd_data_nxt;

  assign rd_data_nxt = rd_en_i ? cur_read : rd_data_r;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_data_r <= `GB_BYTE_ZERO;
    end else begin
      rd_data_r <= rd_data_nxt;
    end
  end

  assign rd_data_o = rd_data_r;

  // ----------------------------------------------------------------
  // wake-up falling edge detection on port a
  // ----------------------------------------------------------------
  // sync resets to zero so a pin held low through reset cannot look
  // like a falling edge once the flops fill
  port_byte_t wake_s1_r;
  port_byte_t wake_s2_r;
  port_byte_t wake_prev_r;
  port_byte_t wake_fall;
  logic wake_req_r, wake_req_nxt;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wake_s1_r <= `GB_SYNC_RST;
      wake_s2_r <= `GB_SYNC_RST;
      wake_prev_r <= `GB_SYNC_RST;
    end else begin
      wake_s1_r <= pin_i[0];
      wake_s2_r <= wake_s1_r;
      wake_prev_r <= wake_s2_r;
    end
  end

  // previous high, current low, pin enabled
  assign wake_fall = wake_prev_r & ~wake_s2_r & wake_en_r;
  assign wake_req_nxt = lowpower_i && (|wake_fall);

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wake_req_r <= 1'b0;
    end else begin
      wake_req_r <= wake_req_nxt;
    end
  end

  assign wake_req_o = wake_req_r;

endmodule : gpio_port_bank

`default_nettype wire

/* logic/gpio_bank_defines.svh */
`ifndef GPIO_BANK_DEFINES_SVH
`define GPIO_BANK_DEFINES_SVH

// ----------------------------------------------------------------
// bank geometry
// ----------------------------------------------------------------
`define GB_NUM_PORTS 7
`define GB_PORT_LAST 3'h6
`define GB_PORT_A 3'h0

// ----------------------------------------------------------------
// register address fields: addr = {port[2:0], kind[1:0]}
// ----------------------------------------------------------------
`define GB_ADDR_W 5
`define GB_PORT_MSB 4
`define GB_PORT_LSB 2
`define GB_KIND_MSB 1
`define GB_KIND_LSB 0
`define GB_KIND_DATA 2'h0
`define GB_KIND_DIR 2'h1
`define GB_KIND_PULLUP 2'h2
`define GB_KIND_WAKE 2'h3

// ----------------------------------------------------------------
// implemented bit masks and reset values
// ----------------------------------------------------------------
`define GB_MASK_FULL 8'hff
`define GB_MASK_PORT_B 8'h3f
`define GB_MASK_PORT_F 8'hf0
`define GB_DATA_RST 8'hff
`define GB_DIR_RST 8'hff
`define GB_PULLUP_RST 8'h00
`define GB_WAKE_RST 8'h00
`define GB_SYNC_RST 8'h00
`define GB_OE_N_RST 8'hff
`define GB_BYTE_ZERO 8'h00
`define GB_BIT_ONE 8'h01

`endif

/* logic/gpio_bank_pkg.sv */
`default_nettype none

package gpio_bank_pkg;

  // ----------------------------------------------------------------
  // access kinds offered by the cpu data port
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ACC_IDLE,
    ACC_WRITE,
    ACC_SET,
    ACC_CLR
  } acc_op_t;

  typedef logic [7:0] port_byte_t;

endpackage : gpio_bank_pkg

`default_nettype wire

/* logic/port_cell.sv */
`include "gpio_bank_defines.svh"
`default_nettype none

// one port: data latch, direction, pull-high and the pad controls
module port_cell
  import gpio_bank_pkg::*;
#(
  parameter port_byte_t IMPL_MASK = `GB_MASK_FULL
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire port_byte_t wr_val_i,
  input wire logic data_we_i,
  input wire logic dir_we_i,
  input wire logic pullup_we_i,
  input wire port_byte_t pin_i,
  output port_byte_t data_o,
  output port_byte_t dir_o,
  output port_byte_t pullup_o,
  output port_byte_t oe_n_o,
  output port_byte_t pull_en_o,
  output port_byte_t read_o
);

  // ----------------------------------------------------------------
  // next values
  // ----------------------------------------------------------------
  port_byte_t data_r, data_nxt;
  port_byte_t dir_r, dir_nxt;
  port_byte_t pullup_r, pullup_nxt;
  port_byte_t oe_n_r, oe_n_nxt;
  port_byte_t pull_en_r, pull_en_nxt;

  // unimplemented bits never store a one, so they read back as zero
  assign data_nxt = data_we_i ? (wr_val_i & IMPL_MASK) : data_r;
  assign dir_nxt = dir_we_i ? (wr_val_i & IMPL_MASK) : dir_r;
  assign pullup_nxt = pullup_we_i ? (wr_val_i & IMPL_MASK) : pullup_r;
  // direction one is input: pad driver off; absent pins never drive
  assign oe_n_nxt = dir_nxt | ~IMPL_MASK;
  // the weak pull-up only acts on a pin that is an input
  assign pull_en_nxt = pullup_nxt & dir_nxt;

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  // reset sets implemented latch and direction bits to one: every pin starts as input
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      data_r <= `GB_DATA_RST & IMPL_MASK;
      dir_r <= `GB_DIR_RST & IMPL_MASK;
      pullup_r <= `GB_PULLUP_RST;
      oe_n_r <= `GB_OE_N_RST;
      pull_en_r <= `GB_PULLUP_RST;
    end else begin
      data_r <= data_nxt;
      dir_r <= dir_nxt;
      pullup_r <= pullup_nxt;
      oe_n_r <= oe_n_nxt;
      pull_en_r <= pull_en_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign data_o = data_r;
  assign dir_o = dir_r;
  assign pullup_o = pullup_r;
  assign oe_n_o = oe_n_r;
  assign pull_en_o = pull_en_r;
  // inputs show the live pin, outputs show the latch, never the pad
  assign read_o = ((dir_r & pin_i) | (~dir_r & data_r)) & IMPL_MASK;

endmodule : port_cell

`default_nettype wire

/* verif/gpio_port_bank_asserts.sv */
`include "gpio_bank_defines.svh"
`default_nettype none

// ----------------------------------------------------------------
// port-level checks of the bank
// ----------------------------------------------------------------
module gpio_port_bank_asserts
  import gpio_bank_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [`GB_ADDR_W-1:0] addr_i,
  input wire acc_op_t op_i,
  input wire port_byte_t wr_data_i,
  input wire logic [2:0] bit_idx_i,
  input wire logic rd_en_i,
  input wire port_byte_t rd_data_o,
  input wire logic [`GB_NUM_PORTS-1:0][7:0] pin_i,
  input wire logic [`GB_NUM_PORTS-1:0][7:0] pin_o,
  input wire logic [`GB_NUM_PORTS-1:0][7:0] pin_oe_n_o,
  input wire logic [`GB_NUM_PORTS-1:0][7:0] pullup_en_o,
  input wire logic lowpower_i,
  input wire logic wake_req_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  // one register access of a given kind at a given address
  sequence s_acc(acc_op_t o, logic [4:0] a);
    op_i == o && addr_i == a;
  endsequence

  // wake pulse must trace back to an a-pin fall two to four edges earlier
  sequence s_fall_seen;
    (|($past(pin_i[0], 3) & ~$past(pin_i[0], 2))) ||
    (|($past(pin_i[0], 4) & ~$past(pin_i[0], 3))) ||
    (|($past(pin_i[0], 5) & ~$past(pin_i[0], 4)));
  endsequence

  a_pullup_input_only: assert property ((pullup_en_o & ~pin_oe_n_o) == '0)
    else $error("pull-up on a driven pin");
  a_unimpl_bits_idle: assert property (pin_oe_n_o[1][7:6] == 2'h3
    && pin_oe_n_o[5][3:0] == 4'hf && pin_o[1][7:6] == 2'h0 && pin_o[5][3:0] == 4'h0)
    else $error("unimplemented bit active");
  a_write_data_latch: assert property (s_acc(ACC_WRITE, 5'h00)
    |=> pin_o[0] == $past(wr_data_i))
    else $error("data latch write lost");
  // direction one is an input, so the pad enable (active low) follows the bit
  a_write_dir_oe: assert property (s_acc(ACC_WRITE, 5'h01)
    |=> pin_oe_n_o[0] == $past(wr_data_i))
    else $error("direction write wrong");
  a_latch_holds: assert property (op_i == ACC_IDLE |=> $stable(pin_o))
    else $error("latch changed without write");
  a_read_port_a: assert property (rd_en_i && addr_i == 5'h00 |=>
    rd_data_o == (($past(pin_i[0]) & $past(pin_oe_n_o[0]))
    | ($past(pin_o[0]) & ~$past(pin_oe_n_o[0]))))
    else $error("port a read wrong");
  a_read_stands: assert property (!rd_en_i |=> $stable(rd_data_o))
    else $error("read data changed without read");
  a_clr_dir_bit: assert property (s_acc(ACC_CLR, 5'h0d) |=> pin_oe_n_o[3] ==
    ($past(pin_oe_n_o[3]) & ~(8'h01 << $past(bit_idx_i))))
    else $error("bit clear wrong");
  a_wake_cause: assert property (wake_req_o |-> s_fall_seen ##0
    ($past(lowpower_i) || $past(lowpower_i, 2)))
    else $error("wake without cause");
endmodule : gpio_port_bank_asserts

`default_nettype wire

/* verif/pin_env.sv */
`default_nettype none

// ----------------------------------------------------------------
// switches and wiring on the far side of the pins
// ----------------------------------------------------------------
module pin_env (
  input wire logic clk_i,
  input wire logic [6:0][7:0] drv_i,
  input wire logic [6:0][7:0] oe_n_i,
  input wire logic [6:0][7:0] pull_i,
  input wire logic [6:0][7:0] sw_drv_i,
  input wire logic [6:0][7:0] sw_lvl_i,
  input wire logic force_i,
  output logic [6:0][7:0] pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0][7:0] float_r = {7{8'h5a}};

  // a floating pin must not settle, or an unknown could pass for a level
  always @(posedge clk_i) float_r <= ~float_r;

  // switch levels only change off the sampling edge; force overpowers the pad
  assign pin_o = force_i ? sw_lvl_i : (~oe_n_i & drv_i) | (oe_n_i & sw_drv_i & sw_lvl_i)
    | (oe_n_i & ~sw_drv_i & (pull_i | float_r));
endmodule : pin_env

`default_nettype wire

/* verif/tb_gpio_port_bank.sv */
`include "gpio_bank_defines.svh"
`default_nettype none

// ----------------------------------------------------------------
// bench for the port bank
// ----------------------------------------------------------------
module tb_gpio_port_bank import gpio_bank_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [`GB_ADDR_W-1:0] addr_i = '0;
  acc_op_t op_i = ACC_IDLE;
  port_byte_t wr_data_i = '0;
  logic [2:0] bit_idx_i = '0;
  logic rd_en_i = 1'b0;
  logic lowpower_i = 1'b0;
  logic sw_force = 1'b0;
  logic [6:0][7:0] sw_drv = '1;
  logic [6:0][7:0] sw_lvl = {7{8'ha5}};
  port_byte_t rd_data_o;
  logic [6:0][7:0] pin_i, pin_o, pin_oe_n_o, pullup_en_o;
  logic wake_req_o;
  int error_cnt = 0;
  int compares = 0;

  always #12.5 clk_i = ~clk_i;

  gpio_port_bank uut (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .op_i(op_i),
    .wr_data_i(wr_data_i), .bit_idx_i(bit_idx_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o),
    .pin_i(pin_i), .pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o), .pullup_en_o(pullup_en_o),
    .lowpower_i(lowpower_i), .wake_req_o(wake_req_o));
  pin_env env (.clk_i(clk_i), .drv_i(pin_o), .oe_n_i(pin_oe_n_o), .pull_i(pullup_en_o),
    .sw_drv_i(sw_drv), .sw_lvl_i(sw_lvl), .force_i(sw_force), .pin_o(pin_i));

  // ----------------------------------------------------------------
  // helpers: all driving starts and ends at a falling edge
  // ----------------------------------------------------------------
  function automatic port_byte_t msk(int p);
    return p == 1 ? `GB_MASK_PORT_B : (p == 5 ? `GB_MASK_PORT_F : `GB_MASK_FULL);
  endfunction : msk
  function automatic logic [4:0] ad(int p, int k);
    return {p[2:0], k[1:0]};
  endfunction : ad
  task chk(input port_byte_t g, input port_byte_t e);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task acc(input logic [4:0] a, input acc_op_t o, input port_byte_t d, input logic r);
    addr_i = a;
    op_i = o;
    wr_data_i = d;
    bit_idx_i = d[2:0];
    rd_en_i = r;
    @(negedge clk_i);
    op_i = ACC_IDLE;
    rd_en_i = 1'b0;
    // one idle edge between requests, so no strobe is driven twice at once
    @(negedge clk_i);
  endtask : acc
  task rc(input logic [4:0] a, input port_byte_t e);
    acc(a, ACC_IDLE, 8'h00, 1'b1);
    chk(rd_data_o, e);
  endtask : rc
  task do_reset();
    resetn_i = 1'b0;
    repeat (20) @(negedge clk_i);
    resetn_i = 1'b1;
  endtask : do_reset
  // a pulse is caught wherever it lands in the window, since latency is loose
  task watch(input logic e);
    logic h;
    h = 1'b0;
    repeat (6) begin
      @(negedge clk_i);
      if (wake_req_o === 1'b1) h = 1'b1;
    end
    chk({7'h0, h}, {7'h0, e});
  endtask : watch
  task give_verdict();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_reset();
    for (int p = 0; p < 7; p++) begin
      rc(ad(p, 0), 8'ha5 & msk(p));
      rc(ad(p, 1), msk(p));
      rc(ad(p, 2), 8'h00);
      chk(pin_o[p], msk(p));
      chk(pin_oe_n_o[p], 8'hff);
      chk(pullup_en_o[p], 8'h00);
    end
    rc(5'h03, 8'h00);
    rc(5'h07, 8'h00);
    $display("test reset done");
  endtask : t_reset
  task t_rw();
    for (int p = 0; p < 7; p++) begin
      acc(ad(p, 1), ACC_WRITE, 8'h00, 1'b0);
      acc(ad(p, 0), ACC_WRITE, 8'h3c, 1'b0);
      acc(ad(p, 2), ACC_WRITE, 8'hff, 1'b0);
      sw_force = 1'b1;
      rc(ad(p, 0), 8'h3c & msk(p));
      sw_force = 1'b0;
      chk(pin_oe_n_o[p], ~msk(p));
      chk(pullup_en_o[p], 8'h00);
      acc(ad(p, 1), ACC_WRITE, 8'hff, 1'b0);
      chk(pullup_en_o[p], msk(p));
      chk(pin_o[p], 8'h3c & msk(p));
    end
    acc(5'h07, ACC_WRITE, 8'hff, 1'b0);
    rc(5'h07, 8'h00);
    // port slot seven is a hole in the map: writes vanish, reads give zero
    acc(5'h1c, ACC_WRITE, 8'hff, 1'b0);
    rc(5'h1c, 8'h00);
    $display("test write readback done");
  endtask : t_rw
  task t_out_high();
    do_reset();
    acc(5'h01, ACC_WRITE, 8'h00, 1'b0);
    chk(pin_o[0], 8'hff);
    chk(pin_i[0], 8'hff);
    $display("test output high done");
  endtask : t_out_high
  task t_live();
    sw_lvl[2] = 8'h5a;
    rc(5'h08, 8'h5a);
    sw_lvl[2] = 8'h81;
    rc(5'h08, 8'h81);
    sw_drv[2] = 8'h00;
    acc(5'h0a, ACC_WRITE, 8'hff, 1'b0);
    rc(5'h08, 8'hff);
    sw_drv[2] = 8'hff;
    $display("test live read done");
  endtask : t_live
  task t_bit();
    sw_lvl[3] = 8'hff;
    acc(5'h0d, ACC_WRITE, 8'hf0, 1'b0);
    acc(5'h0c, ACC_WRITE, 8'h00, 1'b0);
    acc(5'h0c, ACC_SET, 8'h00, 1'b0);
    chk(pin_o[3], 8'hf1);
    // clearing bit 7 of direction 0xf0 leaves 0x70; the pad enable follows it
    acc(5'h0d, ACC_CLR, 8'h07, 1'b0);
    chk(pin_oe_n_o[3], 8'h70);
    acc(5'h05, ACC_SET, 8'h07, 1'b0);
    rc(5'h05, 8'h3f);
    $display("test bit ops done");
  endtask : t_bit
  task t_wake();
    sw_lvl[0] = 8'hff;
    lowpower_i = 1'b1;
    acc(5'h01, ACC_WRITE, 8'hff, 1'b0);
    acc(5'h03, ACC_WRITE, 8'h01, 1'b0);
    rc(5'h03, 8'h01);
    sw_lvl[0] = 8'hfe;
    watch(1'b1);
    sw_lvl[0] = 8'hff;
    repeat (3) @(negedge clk_i);
    sw_lvl[0] = 8'hfd;
    watch(1'b0);
    sw_lvl[0] = 8'hff;
    lowpower_i = 1'b0;
    repeat (3) @(negedge clk_i);
    sw_lvl[0] = 8'hfe;
    watch(1'b0);
    $display("test wake done");
  endtask : t_wake

  // main sequence; the watchdog allows more than ten times the expected run
  initial begin
    do_reset();
    t_reset();
    t_rw();
    t_out_high();
    t_live();
    t_bit();
    t_wake();
    give_verdict();
  end
  initial begin
    repeat (4000) @(posedge clk_i);
    error_cnt++;
    give_verdict();
  end
endmodule : tb_gpio_port_bank

bind gpio_port_bank gpio_port_bank_asserts checks (.clk_i(clk_i), .resetn_i(resetn_i),
  .addr_i(addr_i), .op_i(op_i), .wr_data_i(wr_data_i), .bit_idx_i(bit_idx_i),
  .rd_en_i(rd_en_i), .rd_data_o(rd_data_o), .pin_i(pin_i), .pin_o(pin_o),
  .pin_oe_n_o(pin_oe_n_o), .pullup_en_o(pullup_en_o), .lowpower_i(lowpower_i),
  .wake_req_o(wake_req_o));

`default_nettype wire
